// >>> rtl/rlcirq_pkg.sv
// constants shared by the loop code and zero run interrupt block
package rlcirq_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] LC_STATUS_OFS = 8'h00;
    localparam logic [7:0] LC_ENABLE_OFS = 8'h04;
    localparam logic [7:0] EZ_STATUS_OFS = 8'h08;
    localparam logic [7:0] EZ_ENABLE_OFS = 8'h0c;

    // field positions
    localparam int unsigned DEACT_FLAG_BIT = 0;
    localparam int unsigned ACT_FLAG_BIT   = 1;
    localparam int unsigned DEACT_PRES_BIT = 2;
    localparam int unsigned ACT_PRES_BIT   = 3;
    localparam int unsigned DEACT_EN_BIT   = 0;
    localparam int unsigned ACT_EN_BIT     = 1;
    localparam int unsigned ZERO_FLAG_BIT  = 0;
    localparam int unsigned ZERO_EN_BIT    = 0;

    // event vector layout
    localparam int unsigned NUM_EVT   = 3;
    localparam int unsigned EVT_DEACT = 0;
    localparam int unsigned EVT_ACT   = 1;
    localparam int unsigned EVT_ZERO  = 2;

    // reset values
    localparam logic [1:0] LC_ENABLE_RST = 2'h0;
    localparam logic       EZ_ENABLE_RST = 1'h0;
    localparam logic [7:0] RESERVED_VAL  = 8'h00;

    typedef enum logic {BUS_IDLE, BUS_ACK} rlcirq_bus_state_type;

endpackage

// >>> rtl/rlcirq_if.sv
// carriers between the top and its two helper modules
`timescale 1ns/1ps
interface rlcirq_evt_if #(parameter int unsigned N = 3);
    logic [N-1:0] level;
    logic [N-1:0] clr;
    logic [N-1:0] flag;
    logic [N-1:0] change;
    modport flag_side (input level, input clr, output flag, output change);
    modport user      (output level, output clr, input flag, input change);
endinterface

interface rlcirq_bus_if;
    logic        take;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output take, output we, output adr, output sel,
                   output wdata, input rdata);
    modport regs  (input take, input we, input adr, input sel,
                   input wdata, output rdata);
endinterface

// >>> rtl/rlcirq_edge_flag.sv
// sticky change flags, one per level input
`timescale 1ns/1ps
module rlcirq_edge_flag #(
    parameter int unsigned N = 3
) (
    input  wire logic          clk,  // system clock
    input  wire logic          rstn, // async reset, active low
    rlcirq_evt_if.flag_side    evt   // levels in, flags out
);
    logic [N-1:0] prev_q;
    logic [N-1:0] prev_d;
    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    always_comb
    begin
        prev_d = evt.level;
        evt.change = evt.level ^ prev_q;
        // set beats a clear in the same cycle
        flag_d = (flag_q & ~evt.clr) | evt.change;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_q <= '0;
            flag_q <= '0;
        end
        else
        begin
            prev_q <= prev_d;
            flag_q <= flag_d;
        end
    end

    assign evt.flag = flag_q;
endmodule

// >>> rtl/rlcirq_wb_slave.sv
// classic wishbone slave front end, one access per two cycles
`timescale 1ns/1ps
module rlcirq_wb_slave (
    input  wire logic        clk,      // system clock
    input  wire logic        rstn,     // async reset, active low
    input  wire logic        wb_cyc_i, // bus cycle
    input  wire logic        wb_stb_i, // strobe
    input  wire logic        wb_we_i,  // write
    input  wire logic [7:0]  wb_adr_i, // byte address
    input  wire logic [3:0]  wb_sel_i, // byte lanes
    input  wire logic [31:0] wb_dat_i, // write data
    output logic [31:0]      wb_dat_o, // read data
    output logic             wb_ack_o, // acknowledge
    rlcirq_bus_if.slave      bus       // to register file
);
    rlcirq_pkg::rlcirq_bus_state_type state_q;
    rlcirq_pkg::rlcirq_bus_state_type state_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;

    always_comb
    begin
        state_d  = state_q;
        dat_d    = dat_q;
        bus.take = 1'b0;
        case (state_q)
            rlcirq_pkg::BUS_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    // effects and read capture share this edge
                    bus.take = 1'b1;
                    dat_d    = wb_we_i ? 32'h0000_0000 : bus.rdata;
                    state_d  = rlcirq_pkg::BUS_ACK;
                end
            end
            default:
            begin
                state_d = rlcirq_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= rlcirq_pkg::BUS_IDLE;
            dat_q   <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            dat_q   <= dat_d;
        end
    end

    assign bus.we    = wb_we_i;
    assign bus.adr   = wb_adr_i;
    assign bus.sel   = wb_sel_i;
    assign bus.wdata = wb_dat_i;
    assign wb_dat_o  = dat_q;
    assign wb_ack_o  = (state_q == rlcirq_pkg::BUS_ACK);
endmodule

// >>> rtl/rlcirq_top.sv
// receive loop code and zero run interrupt status and enable block
// Summary of operation
// R1: status bit 2 shows live deactivation code detection, gated by its enable
// R2: status bit 1 sets when activation code detection starts or stops
// R3: status bit 0 sets when deactivation code detection starts or stops
// R4: change flags hold until the status register is read or written with a one; read clears
// R5: enable bit 1 gates activation code change interrupt, reset 0
// R6: enable bit 0 gates deactivation code change interrupt
// R7: zero run status bit 0 sets on detect or clear, clears on read
// R8: a change raises an interrupt only when its enable bit is set
// R9: status bit 3 shows live activation code detection, gated by its enable
// R10: zero run enable bit 0 gates its change interrupt, reset 0
// R11: interrupt stands while any enabled flag is set, drops once cleared
`timescale 1ns/1ps
module rlcirq_top (
    input  wire logic        clk,             // 200 MHz system clock
    input  wire logic        rstn,            // async reset, active low
    input  wire logic        wb_cyc_i,        // bus cycle
    input  wire logic        wb_stb_i,        // strobe
    input  wire logic        wb_we_i,         // write
    input  wire logic [7:0]  wb_adr_i,        // byte address
    input  wire logic [3:0]  wb_sel_i,        // byte lanes
    input  wire logic [31:0] wb_dat_i,        // write data
    output logic [31:0]      wb_dat_o,        // read data
    output logic             wb_ack_o,        // acknowledge
    input  wire logic        act_code_det,    // activation code matched
    input  wire logic        act_detect_en,   // activation detection on
    input  wire logic        deact_code_det,  // deactivation code matched
    input  wire logic        deact_detect_en, // deactivation detection on
    input  wire logic        zero_run_det,    // excessive zeros present
    output logic             irq              // level interrupt, high
);
    localparam int unsigned N = rlcirq_pkg::NUM_EVT;

    rlcirq_evt_if #(.N(N)) evt ();
    rlcirq_bus_if          bus ();

    logic       act_code_present;
    logic       deact_code_present;
    logic [1:0] lc_en_q;
    logic [1:0] lc_en_d;
    logic       ez_en_q;
    logic       ez_en_d;
    logic       irq_q;
    logic       irq_d;
    logic [N-1:0] en_vec;
    logic       rd_lc;
    logic       rd_ez;
    logic       wr_lc;
    logic       wr_ez;
    logic       wr_lce;
    logic       wr_eze;

    // byte lane 0 carries every field; other lanes are don't care
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] ofs,
                                 input logic [3:0] sel);
        hit = (adr == ofs) && sel[0];
    endfunction

    rlcirq_wb_slave u_wb (
        .clk      (clk),
        .rstn     (rstn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .bus      (bus)
    );

    rlcirq_edge_flag #(.N(N)) u_flags (
        .clk  (clk),
        .rstn (rstn),
        .evt  (evt)
    );

    // detector output counts only while its detection is enabled
    assign act_code_present   = act_code_det & act_detect_en;     // R9
    assign deact_code_present = deact_code_det & deact_detect_en; // R1

    // loop code change flags follow the gated levels, so toggling an enable
    // while a code is present also reports a change
    assign evt.level[rlcirq_pkg::EVT_ACT]   = act_code_present;   // R2
    assign evt.level[rlcirq_pkg::EVT_DEACT] = deact_code_present; // R3
    assign evt.level[rlcirq_pkg::EVT_ZERO]  = zero_run_det;       // R7

    assign rd_lc  = bus.take && !bus.we &&
                    hit(bus.adr, rlcirq_pkg::LC_STATUS_OFS, bus.sel);
    assign rd_ez  = bus.take && !bus.we &&
                    hit(bus.adr, rlcirq_pkg::EZ_STATUS_OFS, bus.sel);
    assign wr_lc  = bus.take && bus.we &&
                    hit(bus.adr, rlcirq_pkg::LC_STATUS_OFS, bus.sel);
    assign wr_ez  = bus.take && bus.we &&
                    hit(bus.adr, rlcirq_pkg::EZ_STATUS_OFS, bus.sel);
    assign wr_lce = bus.take && bus.we &&
                    hit(bus.adr, rlcirq_pkg::LC_ENABLE_OFS, bus.sel);
    assign wr_eze = bus.take && bus.we &&
                    hit(bus.adr, rlcirq_pkg::EZ_ENABLE_OFS, bus.sel);

    // clear on read, or write one to clear
    always_comb
    begin
        evt.clr = '0;
        if (rd_lc)
        begin
            evt.clr[rlcirq_pkg::EVT_ACT]   = 1'b1; // R4
            evt.clr[rlcirq_pkg::EVT_DEACT] = 1'b1; // R4
        end
        else if (wr_lc)
        begin
            evt.clr[rlcirq_pkg::EVT_ACT] =
                bus.wdata[rlcirq_pkg::ACT_FLAG_BIT];
            evt.clr[rlcirq_pkg::EVT_DEACT] =
                bus.wdata[rlcirq_pkg::DEACT_FLAG_BIT];
        end
        if (rd_ez)
        begin
            evt.clr[rlcirq_pkg::EVT_ZERO] = 1'b1; // R7
        end
        else if (wr_ez)
        begin
            evt.clr[rlcirq_pkg::EVT_ZERO] =
                bus.wdata[rlcirq_pkg::ZERO_FLAG_BIT];
        end
    end

    // read mux; unmapped addresses read zero and ignore writes
    always_comb
    begin
        bus.rdata = 32'h0000_0000;
        if (bus.adr == rlcirq_pkg::LC_STATUS_OFS)
        begin
            bus.rdata[7:0] = rlcirq_pkg::RESERVED_VAL;
            bus.rdata[rlcirq_pkg::ACT_PRES_BIT]   = act_code_present;
            bus.rdata[rlcirq_pkg::DEACT_PRES_BIT] = deact_code_present;
            bus.rdata[rlcirq_pkg::ACT_FLAG_BIT]   =
                evt.flag[rlcirq_pkg::EVT_ACT];
            bus.rdata[rlcirq_pkg::DEACT_FLAG_BIT] =
                evt.flag[rlcirq_pkg::EVT_DEACT];
        end
        else if (bus.adr == rlcirq_pkg::LC_ENABLE_OFS)
        begin
            bus.rdata[1:0] = lc_en_q;
        end
        else if (bus.adr == rlcirq_pkg::EZ_STATUS_OFS)
        begin
            bus.rdata[rlcirq_pkg::ZERO_FLAG_BIT] =
                evt.flag[rlcirq_pkg::EVT_ZERO];
        end
        else if (bus.adr == rlcirq_pkg::EZ_ENABLE_OFS)
        begin
            bus.rdata[rlcirq_pkg::ZERO_EN_BIT] = ez_en_q;
        end
    end

    // enables and interrupt
    always_comb
    begin
        lc_en_d = lc_en_q;
        ez_en_d = ez_en_q;
        if (wr_lce)
        begin
            lc_en_d[rlcirq_pkg::ACT_EN_BIT] =
                bus.wdata[rlcirq_pkg::ACT_EN_BIT];     // R5
            lc_en_d[rlcirq_pkg::DEACT_EN_BIT] =
                bus.wdata[rlcirq_pkg::DEACT_EN_BIT];   // R6
        end
        if (wr_eze)
        begin
            ez_en_d = bus.wdata[rlcirq_pkg::ZERO_EN_BIT]; // R10
        end
        en_vec = '0;
        en_vec[rlcirq_pkg::EVT_ACT]   = lc_en_q[rlcirq_pkg::ACT_EN_BIT];
        en_vec[rlcirq_pkg::EVT_DEACT] = lc_en_q[rlcirq_pkg::DEACT_EN_BIT];
        en_vec[rlcirq_pkg::EVT_ZERO]  = ez_en_q;
        // disabled flags still latch but never reach the pin
        irq_d = |(evt.flag & en_vec); // R8 R11
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lc_en_q <= rlcirq_pkg::LC_ENABLE_RST;
            ez_en_q <= rlcirq_pkg::EZ_ENABLE_RST;
            irq_q   <= 1'b0;
        end
        else
        begin
            lc_en_q <= lc_en_d;
            ez_en_q <= ez_en_d;
            irq_q   <= irq_d;
        end
    end

    assign irq = irq_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    pres_deact_a: assert property ( // R1
        rd_lc |=> wb_ack_o &&
            wb_dat_o[rlcirq_pkg::DEACT_PRES_BIT] ==
            $past(deact_code_det && deact_detect_en))
        else $error("deactivation code state read wrong");

    act_change_a: assert property ( // R2
        act_code_present != $past(act_code_present)
        |=> evt.flag[rlcirq_pkg::EVT_ACT])
        else $error("activation code change not flagged");

    deact_change_a: assert property ( // R3
        $changed(deact_code_present)
        |=> evt.flag[rlcirq_pkg::EVT_DEACT])
        else $error("deactivation code change not flagged");

    read_clear_a: assert property ( // R4
        rd_lc && !evt.change[rlcirq_pkg::EVT_ACT]
              && !evt.change[rlcirq_pkg::EVT_DEACT]
        |=> !evt.flag[rlcirq_pkg::EVT_ACT]
            && !evt.flag[rlcirq_pkg::EVT_DEACT] ##1 !wb_ack_o)
        else $error("loop code flags not cleared by read");

    flag_hold_a: assert property ( // R4
        evt.flag[rlcirq_pkg::EVT_ACT] && !rd_lc && !wr_lc
        |=> evt.flag[rlcirq_pkg::EVT_ACT])
        else $error("activation flag dropped without read");

    act_en_a: assert property ( // R5
        wr_lce |=> lc_en_q[rlcirq_pkg::ACT_EN_BIT] ==
                   $past(wb_dat_i[rlcirq_pkg::ACT_EN_BIT]))
        else $error("activation enable not written");

    deact_en_a: assert property ( // R6
        wr_lce |=> ##1 lc_en_q[rlcirq_pkg::DEACT_EN_BIT] ==
                   $past(wb_dat_i[rlcirq_pkg::DEACT_EN_BIT], 2))
        else $error("deactivation enable not written");

    zero_change_a: assert property ( // R7
        $changed(zero_run_det) |=> evt.flag[rlcirq_pkg::EVT_ZERO]
            ##1 (evt.flag[rlcirq_pkg::EVT_ZERO]
                 || $past(rd_ez || wr_ez)))
        else $error("zero run change not flagged");

    irq_gate_a: assert property ( // R8
        (evt.flag & en_vec) == '0 |=> !irq)
        else $error("interrupt without enabled flag");

    pres_act_a: assert property ( // R9
        rd_lc |=> wb_dat_o[rlcirq_pkg::ACT_PRES_BIT] ==
                  $past(act_code_det && act_detect_en))
        else $error("activation code state read wrong");

    zero_en_a: assert property ( // R10
        wr_eze |=> ez_en_q == $past(wb_dat_i[rlcirq_pkg::ZERO_EN_BIT]))
        else $error("zero run enable not written");

    irq_raise_a: assert property ( // R11
        ez_en_q && evt.flag[rlcirq_pkg::EVT_ZERO] |=> irq)
        else $error("enabled zero run flag gave no interrupt");

    irq_loop_a: assert property ( // R11
        (evt.flag[rlcirq_pkg::EVT_ACT] && lc_en_q[rlcirq_pkg::ACT_EN_BIT])
        || (evt.flag[rlcirq_pkg::EVT_DEACT]
            && lc_en_q[rlcirq_pkg::DEACT_EN_BIT])
        |=> irq)
        else $error("enabled loop code flag gave no interrupt");

    irq_drop_a: assert property ( // R11
        irq && !evt.flag[rlcirq_pkg::EVT_ACT]
            && !evt.flag[rlcirq_pkg::EVT_DEACT]
            && !evt.flag[rlcirq_pkg::EVT_ZERO] |=> !irq)
        else $error("interrupt held after all flags cleared");

    deact_hold_a: assert property ( // R4
        evt.flag[rlcirq_pkg::EVT_DEACT] && !rd_lc && !wr_lc
        |=> evt.flag[rlcirq_pkg::EVT_DEACT])
        else $error("deactivation flag dropped without read");

    zero_hold_a: assert property ( // R7
        evt.flag[rlcirq_pkg::EVT_ZERO] && !rd_ez && !wr_ez
        |=> evt.flag[rlcirq_pkg::EVT_ZERO])
        else $error("zero run flag dropped without read");

    zero_clear_a: assert property ( // R7
        rd_ez && !evt.change[rlcirq_pkg::EVT_ZERO]
        |=> !evt.flag[rlcirq_pkg::EVT_ZERO])
        else $error("zero run flag not cleared by read");

    wc_clear_a: assert property (
        wr_lc && bus.wdata[rlcirq_pkg::ACT_FLAG_BIT]
              && !evt.change[rlcirq_pkg::EVT_ACT]
        |=> !evt.flag[rlcirq_pkg::EVT_ACT])
        else $error("activation flag not cleared by write one");

    bus_ack_a: assert property (
        bus.take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle after request");

    act_evt_c: cover property (
        lc_en_q[rlcirq_pkg::ACT_EN_BIT] && $rose(act_code_present)
        ##[1:20] irq);
    read_clr_c: cover property (
        irq && rd_lc ##2 !irq);
    set_wins_c: cover property (
        rd_ez && evt.change[rlcirq_pkg::EVT_ZERO]);
    zero_irq_c: cover property (
        ez_en_q && $fell(zero_run_det) ##[1:4] irq);
    w1c_c: cover property (
        wr_lc && evt.flag[rlcirq_pkg::EVT_ACT]
        ##1 !evt.flag[rlcirq_pkg::EVT_ACT]);
endmodule

// >>> tb/rlcirq_line_model.sv
// far end line model: drives detector levels after a chosen lag
`timescale 1ns/1ps
module rlcirq_line_model (
    input  wire logic       clk,            // system clock
    input  wire logic       rstn,           // async reset, active low
    input  wire logic [2:0] want,           // {zero, deact, act} wanted
    input  wire logic [1:0] lag,            // cycles of line delay beyond the first
    output logic            act_code_det,   // activation code seen
    output logic            deact_code_det, // deactivation code seen
    output logic            zero_run_det    // zero run seen
);
    logic [2:0] pipe_q [0:3];

    // a slow line shows the new pattern only after the lag has run out
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++)
                pipe_q[i] <= 3'h0;
        end
        else
        begin
            pipe_q[0] <= want;
            for (int i = 1; i < 4; i++)
                pipe_q[i] <= pipe_q[i-1];
        end
    end

    assign {zero_run_det, deact_code_det, act_code_det} = pipe_q[lag];
endmodule

// >>> tb/tb.sv
// self-checking bench for the loop code and zero run interrupt block
`timescale 1ns/1ps
module tb;
    logic        clk, rstn, cyc, stb, we, irq, ack, act_en, deact_en;
    logic        act_det, deact_det, zero_det;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, seed;
    logic [2:0]  want;
    logic [1:0]  lag;
    logic [31:0] exp_q [$];
    int          fails, total_checks;

    rlcirq_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .act_code_det(act_det),
        .act_detect_en(act_en), .deact_code_det(deact_det),
        .deact_detect_en(deact_en), .zero_run_det(zero_det), .irq(irq));

    rlcirq_line_model line_m (.clk(clk), .rstn(rstn), .want(want),
        .lag(lag), .act_code_det(act_det), .deact_code_det(deact_det),
        .zero_run_det(zero_det));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h000000, d};
        sel <= s;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 100);
        if (n >= 100)
            chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [3:0] s = 4'h1);
        exp_q.push_back({24'h000000, e});
        wb(1'b0, a, 8'h00, s);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic line(input logic [2:0] w);
        @(posedge clk);
        want <= w;
        lag  <= xs() % 4;
        tick(8);
    endtask

    task automatic chk_irq(input logic e);
        @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    // read results are judged against the oldest note at each read ack
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk("read queue", 32'h1, 32'h0);
            else
                chk("read data", exp_q.pop_front(), rdat);
        end
    end

    initial
    begin
        #250000;
        fails++;
        test_done();
    end

    initial
    begin
        logic [31:0] r;
        seed = 32'h0000542a;
        fails = 0;
        total_checks = 0;
        {rstn, cyc, stb, we, adr, sel, dat, want, lag} = '0;
        act_en = 1'b1;
        deact_en = 1'b1;
        tick(8);
        rstn <= 1'b1;
        tick(2);
        for (int a = 0; a <= 16; a += 4)
            rd(a[7:0], 8'h00);
        chk_irq(1'b0);
        repeat (4)
        begin
            r = xs();
            wr(8'h04, r[7:0]);
            rd(8'h04, {6'h00, r[1:0]});
            wr(8'h0c, r[7:0]);
            rd(8'h0c, {7'h00, r[0]});
        end
        wr(8'h04, 8'h00);
        wr(8'h0c, 8'h00);
        line(3'b001);
        rd(8'h00, 8'h0a);
        chk_irq(1'b0);
        rd(8'h00, 8'h08);
        line(3'b000);
        rd(8'h00, 8'h02);
        rd(8'h00, 8'h00);
        line(3'b010);
        rd(8'h00, 8'h05);
        deact_en <= 1'b0;
        tick(3);
        rd(8'h00, 8'h01);
        deact_en <= 1'b1;
        line(3'b000);
        rd(8'h00, 8'h01);
        rd(8'h00, 8'h00);
        line(3'b100);
        rd(8'h08, 8'h01);
        rd(8'h08, 8'h00);
        line(3'b000);
        rd(8'h08, 8'h01, 4'h0);
        rd(8'h08, 8'h01);
        rd(8'h08, 8'h00);
        // zero run interrupt: mask, unmask, write one to clear
        wr(8'h0c, 8'h01);
        chk_irq(1'b0);
        line(3'b100);
        chk_irq(1'b1);
        wr(8'h0c, 8'h00);
        tick(2);
        chk_irq(1'b0);
        wr(8'h0c, 8'h01);
        tick(2);
        chk_irq(1'b1);
        wr(8'h08, 8'h01);
        tick(2);
        chk_irq(1'b0);
        rd(8'h08, 8'h00);
        wr(8'h0c, 8'h00);
        line(3'b000);
        rd(8'h08, 8'h01);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h04, 8'h01 << i);
            line(i ? 3'b010 : 3'b001);
            chk_irq(1'b0);
            line(3'b011);
            chk_irq(1'b1);
            rd(8'h00, 8'h0f);
            tick(2);
            chk_irq(1'b0);
            line(3'b000);
            rd(8'h00, 8'h03);
            wr(8'h04, 8'h00);
        end
        // write one to clear on the loop code flags, then a reset mid-run
        line(3'b001);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h0a, 4'h0);
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h08);
        wr(8'h04, 8'h03);
        wr(8'h0c, 8'h01);
        line(3'b000);
        chk_irq(1'b1);
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        tick(2);
        chk_irq(1'b0);
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h0c, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        tick(4);
        chk("queue empty", 32'h0, exp_q.size());
        test_done();
    end
endmodule
